// *** core/ceir_top.sv ***
/*
  Forward sideband control channel error injection and remote target
  address remap, with an Avalon-MM register slave (word addressed).
  Assumes frames arrive on i_clk from the channel framer and that
  alias matching is done upstream and given as alias_sel.
*/
`timescale 1ns/1ps
`include "ceir_consts.svh"

module ceir_top (
  input  wire logic                 i_clk,
  input  wire logic                 i_arst_n,
  input  wire logic [7:0]           i_avs_address,
  input  wire logic                 i_avs_read,
  input  wire logic                 i_avs_write,
  input  wire logic [31:0]          i_avs_writedata,
  input  wire logic [3:0]           i_avs_byteenable,
  output logic      [31:0]          o_avs_readdata,
  output logic                      o_avs_waitrequest,
  input  wire ceir_pkg::ceir_frame_t i_fwd_frame,
  output ceir_pkg::ceir_frame_t     o_fwd_frame,
  output logic                      o_err_pending
);

  logic                  ack_q, ack_d;
  logic [31:0]           rdata_q, rdata_d;
  logic [2:0]            type_q, type_d;
  logic [2:0]            index_q, index_d;
  logic [6:0]            tgt_q [3];
  logic [6:0]            tgt_d [3];
  logic                  armed_q, armed_d;
  logic [3:0]            pos_q, pos_d;
  logic [3:0]            seq_ofs_q, seq_ofs_d;
  logic [7:0]            lfsr_q, lfsr_d;
  ceir_pkg::ceir_frame_t out_q, out_d;
  logic                  wr_ok, rd_ok, lane0;
  logic                  force_wr, hit;
  logic [3:0]            cur_idx;
  logic [7:0]            rm_data;
  logic [2:0]            rand_bit;

  // Slave answers with one wait cycle so read data come from a flop
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr_ok             = i_avs_write & ack_q;
  assign rd_ok             = i_avs_read & ack_q;
  assign lane0             = i_avs_byteenable[0];
  assign o_avs_readdata    = rdata_q;
  assign o_fwd_frame       = out_q;
  assign o_err_pending     = armed_q;

  assign force_wr = wr_ok & lane0 & (i_avs_address == `CEIR_IDX_ERR_INJ)
                  & i_avs_writedata[`CEIR_FORCE_BIT];

  assign cur_idx = i_fwd_frame.sot ? 4'h0 : pos_q;
  assign hit     = armed_q & i_fwd_frame.valid & (cur_idx == {1'h0, index_q});

  // Spread of the LFSR over 1..7 is slightly uneven; fine for test use
  assign rand_bit = 3'(lfsr_q[2:0] % 3'h7) + 3'h1;

  always_comb begin
    ack_d   = (i_avs_read | i_avs_write) & ~ack_q;
    rdata_d = rdata_q;
    if (ack_d) begin
      rdata_d = 32'h0000_0000;
      case (i_avs_address)
        `CEIR_IDX_ERR_INJ:   rdata_d[7:0] = {2'h0, type_q, index_q};
        // target address in upper seven bits
        `CEIR_IDX_TGT_ONE:   rdata_d[7:0] = {tgt_q[0], 1'h0};
        `CEIR_IDX_TGT_TWO:   rdata_d[7:0] = {tgt_q[1], 1'h0};
        `CEIR_IDX_TGT_THREE: rdata_d[7:0] = {tgt_q[2], 1'h0};
        default:             rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    type_d  = type_q;
    index_d = index_q;
    for (int i = 0; i < 3; i++) begin
      tgt_d[i] = tgt_q[i];
    end
    if (wr_ok & lane0) begin
      case (i_avs_address)
        `CEIR_IDX_ERR_INJ: begin
          type_d  = i_avs_writedata[`CEIR_TYPE_LSB +: 3];
          index_d = i_avs_writedata[`CEIR_INDEX_LSB +: 3];
        end
        `CEIR_IDX_TGT_ONE:   tgt_d[0] = i_avs_writedata[`CEIR_TGT_LSB +: 7];
        `CEIR_IDX_TGT_TWO:   tgt_d[1] = i_avs_writedata[`CEIR_TGT_LSB +: 7];
        `CEIR_IDX_TGT_THREE: tgt_d[2] = i_avs_writedata[`CEIR_TGT_LSB +: 7];
        default:             type_d = type_q;
      endcase
    end
  end

  always_comb begin
    lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    pos_d  = pos_q;
    if (i_fwd_frame.valid) begin
      pos_d = (cur_idx == `CEIR_LAST_INDEX) ? cur_idx : cur_idx + 4'h1;
    end
    // one shot; a new force in the same cycle as use wins
    armed_d = hit ? 1'h0 : armed_q;
    if (force_wr) begin
      armed_d = 1'h1;
    end
  end

  always_comb begin
    rm_data = i_fwd_frame.data;
    // alias remap on the address byte
    if (i_fwd_frame.sot && i_fwd_frame.alias_sel != 2'h0) begin
      rm_data[7:1] = tgt_q[i_fwd_frame.alias_sel - 2'h1];
    end
    seq_ofs_d    = seq_ofs_q;
    out_d        = i_fwd_frame;
    out_d.data   = rm_data;
    out_d.seq    = i_fwd_frame.seq + seq_ofs_q;
    if (hit) begin
      case (ceir_pkg::ceir_err_t'(type_q))
        ceir_pkg::CEIR_ERR_CRC:  out_d.crc = ~i_fwd_frame.crc;
        // skip one sequence number from here on
        ceir_pkg::CEIR_ERR_SEQ: begin
          seq_ofs_d = seq_ofs_q + 4'h1;
          out_d.seq = i_fwd_frame.seq + seq_ofs_q + 4'h1;
        end
        ceir_pkg::CEIR_ERR_DROP: out_d.valid = 1'h0;
        ceir_pkg::CEIR_ERR_RAND: out_d.data = rm_data ^ (8'h01 << rand_bit);
        ceir_pkg::CEIR_ERR_BIT0: out_d.data = rm_data ^ 8'h01;
        // none and reserved codes leave the frame intact
        default:                 out_d = out_d;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_q     <= 1'h0;
      rdata_q   <= 32'h0000_0000;
      type_q    <= `CEIR_RST_TYPE;
      index_q   <= `CEIR_RST_INDEX;
      for (int i = 0; i < 3; i++) begin
        tgt_q[i] <= `CEIR_RST_TGT;
      end
      armed_q   <= 1'h0;
      pos_q     <= 4'h0;
      seq_ofs_q <= 4'h0;
      lfsr_q    <= `CEIR_LFSR_SEED;
      out_q     <= '0;
    end else begin
      ack_q     <= ack_d;
      rdata_q   <= rdata_d;
      type_q    <= type_d;
      index_q   <= index_d;
      for (int i = 0; i < 3; i++) begin
        tgt_q[i] <= tgt_d[i];
      end
      armed_q   <= armed_d;
      pos_q     <= pos_d;
      seq_ofs_q <= seq_ofs_d;
      lfsr_q    <= lfsr_d;
      out_q     <= out_d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  property p_force_reads_zero;
    rd_ok && i_avs_address == `CEIR_IDX_ERR_INJ |-> o_avs_readdata[`CEIR_FORCE_BIT] == 1'h0;
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero) else $error("force bit read nonzero");

  property p_force_arms;
    force_wr |=> o_err_pending;
  endproperty
  a_force_arms: assert property (p_force_arms) else $error("force write did not arm");

  property p_none_intact;
    hit && type_q == 3'h0 |=> o_fwd_frame.valid && o_fwd_frame.crc == $past(i_fwd_frame.crc)
      && o_fwd_frame.data == $past(rm_data);
  endproperty
  a_none_intact: assert property (p_none_intact) else $error("type none altered frame");

  property p_crc;
    hit && type_q == 3'h1 |=> o_fwd_frame.crc == ~$past(i_fwd_frame.crc);
  endproperty
  a_crc: assert property (p_crc) else $error("crc not corrupted");

  property p_seq;
    hit && type_q == 3'h2 |=> o_fwd_frame.seq == $past(i_fwd_frame.seq) + $past(seq_ofs_q) + 4'h1;
  endproperty
  a_seq: assert property (p_seq) else $error("sequence not skipped by one");

  property p_drop;
    hit && type_q == 3'h3 |=> !o_fwd_frame.valid;
  endproperty
  a_drop: assert property (p_drop) else $error("frame not dropped");

  property p_rand;
    hit && type_q == 3'h4 |=> o_fwd_frame.data[0] == $past(rm_data[0])
      && $countones(o_fwd_frame.data ^ $past(rm_data)) == 1;
  endproperty
  a_rand: assert property (p_rand) else $error("random flip wrong");

  property p_bit0;
    hit && type_q == 3'h5 |=> o_fwd_frame.data == ($past(rm_data) ^ 8'h01);
  endproperty
  a_bit0: assert property (p_bit0) else $error("bit0 not flipped");

  property p_index_fires;
    armed_q && !force_wr && i_fwd_frame.valid && cur_idx == {1'h0, index_q} |=> !o_err_pending;
  endproperty
  a_index_fires: assert property (p_index_fires) else $error("selected byte missed");

  property p_tgt_read;
    rd_ok && i_avs_address == `CEIR_IDX_TGT_ONE |-> o_avs_readdata == {24'h0, tgt_q[0], 1'h0};
  endproperty
  a_tgt_read: assert property (p_tgt_read) else $error("target readback wrong");

  property p_remap;
    i_fwd_frame.valid && i_fwd_frame.sot && i_fwd_frame.alias_sel == 2'h2 && !hit
      |=> o_fwd_frame.data[7:1] == $past(tgt_q[1]);
  endproperty
  a_remap: assert property (p_remap) else $error("alias not remapped");

  property p_no_extra;
    !armed_q && i_fwd_frame.valid |=> o_fwd_frame.valid && o_fwd_frame.crc == $past(i_fwd_frame.crc);
  endproperty
  a_no_extra: assert property (p_no_extra) else $error("error without force");

  property p_reserved_intact;
    hit && type_q[2:1] == 2'h3 |=> o_fwd_frame.valid && o_fwd_frame.data == $past(rm_data)
      && o_fwd_frame.crc == $past(i_fwd_frame.crc)
      && o_fwd_frame.seq == $past(i_fwd_frame.seq) + $past(seq_ofs_q);
  endproperty
  a_reserved_intact: assert property (p_reserved_intact) else $error("reserved type altered frame");

  property p_type_write;
    wr_ok && lane0 && i_avs_address == `CEIR_IDX_ERR_INJ
      |=> type_q == $past(i_avs_writedata[`CEIR_TYPE_LSB +: 3]);
  endproperty
  a_type_write: assert property (p_type_write) else $error("error type not stored");

  property p_index_write;
    wr_ok && lane0 && i_avs_address == `CEIR_IDX_ERR_INJ
      |=> index_q == $past(i_avs_writedata[`CEIR_INDEX_LSB +: 3]);
  endproperty
  a_index_write: assert property (p_index_write) else $error("frame index not stored");

  property p_tgt_write;
    wr_ok && lane0 && i_avs_address == `CEIR_IDX_TGT_TWO
      |=> tgt_q[1] == $past(i_avs_writedata[`CEIR_TGT_LSB +: 7]);
  endproperty
  a_tgt_write: assert property (p_tgt_write) else $error("target address not stored");

  // Writes without the low byte lane must leave every field alone
  property p_lane_ignored;
    wr_ok && !lane0 |=> $stable(type_q) && $stable(index_q) && $stable(tgt_q[0])
      && $stable(tgt_q[1]) && $stable(tgt_q[2]);
  endproperty
  a_lane_ignored: assert property (p_lane_ignored) else $error("write without low lane changed a field");

  property p_rdata_upper;
    rd_ok |-> o_avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read data bits not zero");

  property p_remap_one;
    i_fwd_frame.valid && i_fwd_frame.sot && i_fwd_frame.alias_sel == 2'h1 && !hit
      |=> o_fwd_frame.data == {$past(tgt_q[0]), $past(i_fwd_frame.data[0])};
  endproperty
  a_remap_one: assert property (p_remap_one) else $error("alias one not remapped");

  // Without a start byte alias the address passes untouched
  property p_no_alias;
    i_fwd_frame.valid && (!i_fwd_frame.sot || i_fwd_frame.alias_sel == 2'h0) && !hit
      |=> o_fwd_frame.data == $past(i_fwd_frame.data);
  endproperty
  a_no_alias: assert property (p_no_alias) else $error("data changed without alias");

  property p_seq_kept;
    i_fwd_frame.valid && !hit |=> o_fwd_frame.seq == $past(i_fwd_frame.seq) + $past(seq_ofs_q);
  endproperty
  a_seq_kept: assert property (p_seq_kept) else $error("sequence offset lost");

  property p_pend_holds;
    o_err_pending && !hit |=> o_err_pending;
  endproperty
  a_pend_holds: assert property (p_pend_holds) else $error("armed error lost before use");

  property p_no_spont_arm;
    !o_err_pending && !force_wr |=> !o_err_pending;
  endproperty
  a_no_spont_arm: assert property (p_no_spont_arm) else $error("error armed without force write");

  c_crc:   cover property (hit && type_q == 3'h1);
  c_drop:  cover property (hit && type_q == 3'h3);
  c_remap: cover property (i_fwd_frame.valid && i_fwd_frame.sot && i_fwd_frame.alias_sel == 2'h3);
  c_seq:   cover property (hit && type_q == 3'h2);
  c_rand:  cover property (hit && type_q == 3'h4);

endmodule // ceir_top

// *** inc/ceir_consts.svh ***
/*
  Register indices, field positions, reset values for the sideband
  control channel error injection and remote target remap block.
  Assumes inclusion from design files only.
*/
`ifndef CEIR_CONSTS_SVH
`define CEIR_CONSTS_SVH
`define CEIR_IDX_ERR_INJ   8'h06
`define CEIR_IDX_TGT_ONE   8'h70
`define CEIR_IDX_TGT_TWO   8'h71
`define CEIR_IDX_TGT_THREE 8'h72
`define CEIR_FORCE_BIT     6
`define CEIR_TYPE_LSB      3
`define CEIR_INDEX_LSB     0
`define CEIR_TGT_LSB       1
`define CEIR_RST_TYPE      3'h0
`define CEIR_RST_INDEX     3'h0
`define CEIR_RST_TGT       7'h00
`define CEIR_LFSR_SEED     8'hA5
`define CEIR_LAST_INDEX    4'h8
`endif

// *** inc/ceir_pkg.sv ***
/*
  Types for the error injection and remap block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ceir_pkg;
  typedef enum logic [2:0] {
    CEIR_ERR_NONE  = 3'h0,
    CEIR_ERR_CRC   = 3'h1,
    CEIR_ERR_SEQ   = 3'h2,
    CEIR_ERR_DROP  = 3'h3,
    CEIR_ERR_RAND  = 3'h4,
    CEIR_ERR_BIT0  = 3'h5
  } ceir_err_t;

  // One forward control channel byte with its framing fields
  typedef struct packed {
    logic       valid;
    logic       sot;
    logic [1:0] alias_sel;
    logic [3:0] seq;
    logic [7:0] data;
    logic [7:0] crc;
  } ceir_frame_t;
endpackage

// *** dv/ceir_remote_model.sv ***
/*
  Remote end of the forward control channel: counts sequence gaps.
  Assumes one frame per valid cycle and a 4-bit wrapping sequence.
*/
`timescale 1ns/1ps
module ceir_remote_model (
  input  wire logic                  i_clk,
  input  wire logic                  i_arst_n,
  input  wire ceir_pkg::ceir_frame_t i_frame,
  output logic      [7:0]            o_gaps
);
  logic       seen_q;
  logic [3:0] last_q;
  // Skipped or dropped frames show as a gap
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      seen_q <= 1'h0;
      last_q <= 4'h0;
      o_gaps <= 8'h00;
    end else if (i_frame.valid) begin
      seen_q <= 1'h1;
      last_q <= i_frame.seq;
      if (seen_q && i_frame.seq != last_q + 4'h1) begin
        o_gaps <= o_gaps + 8'h01;
      end
    end
  end
endmodule // ceir_remote_model

// *** dv/tb_ceir_top.sv ***
/*
  Bench for ceir_top: register bus, alias remap and forced errors.
  Assumes a one-wait-state Avalon slave and a one-cycle frame path.
*/
`timescale 1ns/1ps
module tb_ceir_top;
  logic                  i_clk;
  logic                  i_arst_n;
  logic [7:0]            adr;
  logic                  rd;
  logic                  wr;
  logic [31:0]           wd;
  logic [3:0]            be;
  logic [31:0]           rdata;
  logic                  wreq;
  logic                  pend;
  logic [7:0]            gaps;
  ceir_pkg::ceir_frame_t fin;
  ceir_pkg::ceir_frame_t fout;
  ceir_pkg::ceir_frame_t g;
  ceir_pkg::ceir_frame_t e;
  logic [31:0]           q;
  logic [3:0]            gseq;
  logic [3:0]            off;
  int                    mismatches;
  int                    num_checks;
  logic [7:0]            ra [5] = '{8'h06, 8'h70, 8'h71, 8'h72, 8'h10};
  logic [7:0]            rv [5] = '{8'h00, 8'hA8, 8'h32, 8'hFE, 8'h00};
  logic [7:0]            rows [4][3] = '{'{8'h01, 8'h41, 8'hA9}, '{8'h02, 8'h40, 8'h32},
                                         '{8'h03, 8'h01, 8'hFF}, '{8'h00, 8'h5A, 8'h5A}};

  ceir_top dut (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wreq), .i_fwd_frame(fin), .o_fwd_frame(fout), .o_err_pending(pend));
  ceir_remote_model far_end (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_frame(fout), .o_gaps(gaps));

  initial begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] y);
    num_checks++;
    if (y !== x) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, x, y);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] b,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge i_clk);
    adr <= a;
    wd <= {24'h000000, d};
    be <= b;
    wr <= w;
    rd <= !w;
    // Waitrequest and read data are taken at the same rising edge
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'h0);
    r = rdata;
    wr <= 1'h0;
    rd <= 1'h0;
    chk("wait_edges", 32'h2, n);
  endtask

  task automatic send(input logic s, input logic [1:0] al, input logic [7:0] d, output ceir_pkg::ceir_frame_t o);
    @(posedge i_clk);
    fin <= '{1'h1, s, al, gseq, d, 8'hC3 ^ d};
    gseq = gseq + 4'h1;
    @(posedge i_clk);
    fin <= '0;
    #1 o = fout;
  endtask

  task automatic frm(input ceir_pkg::ceir_frame_t x, input ceir_pkg::ceir_frame_t y, input logic c);
    chk("valid", x.valid, y.valid);
    if (x.valid) begin
      chk("sot", x.sot, y.sot);
      chk("seq", x.seq, y.seq);
      chk("data", x.data, y.data);
      if (c) chk("crc", x.crc, y.crc);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    close_out;
  end

  initial begin
    {adr, rd, wr, wd, be, fin, gseq, off, mismatches, num_checks} = '0;
    i_arst_n = 1'h0;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'h1;
    for (int i = 0; i < 5; i++) begin
      bus(1'h0, ra[i], 8'h00, 4'hF, q);
      chk("reset", 32'h0, q);
    end
    bus(1'h1, 8'h70, 8'hA9, 4'hF, q);
    bus(1'h1, 8'h71, 8'h33, 4'hF, q);
    bus(1'h1, 8'h72, 8'hFE, 4'hF, q);
    bus(1'h1, 8'h71, 8'h00, 4'hE, q);
    bus(1'h1, 8'h10, 8'hFF, 4'hF, q);
    for (int i = 0; i < 5; i++) begin
      bus(1'h0, ra[i], 8'h00, 4'hF, q);
      chk("readback", rv[i], q);
    end
    foreach (rows[i]) begin
      e = '{1'h1, 1'h1, rows[i][0][1:0], gseq + off, rows[i][2], 8'h00};
      send(1'h1, rows[i][0][1:0], rows[i][1], g);
      frm(e, g, 1'h0);
    end
    // Types 0 to 6, index running 7 down to 1, then a clean transfer
    for (int t = 0; t < 7; t++) begin
      bus(1'h1, 8'h06, {2'h1, t[2:0], 3'(7 - t)}, 4'hF, q);
      @(posedge i_clk);
      #1 chk("pend_set", 32'h1, pend);
      bus(1'h0, 8'h06, 8'h00, 4'hF, q);
      chk("ctrl_read", {26'h0, t[2:0], 3'(7 - t)}, q);
      for (int p = 0; p < 2; p++) begin
        for (int j = 0; j < 8; j++) begin
          e = '{1'h1, j == 0, 2'h0, gseq + off, 8'h10 + 8'(j), 8'hC3 ^ (8'h10 + 8'(j))};
          if (p == 0 && j == 7 - t) begin
            case (t)
              1: e.crc = ~e.crc;
              2: begin
                off = off + 4'h1;
                e.seq = e.seq + 4'h1;
              end
              3: e.valid = 1'h0;
              5: e.data[0] = ~e.data[0];
              default: ;
            endcase
          end
          send(e.sot, 2'h0, 8'h10 + 8'(j), g);
          if (p == 0 && j == 7 - t && t == 4)
            chk("flip", 32'h1, $countones(g.data ^ e.data) == 1 && g.data[0] === e.data[0]);
          else
            frm(e, g, 1'h1);
        end
        chk("pend_used", 32'h0, pend);
      end
    end
    // Index zero lands on the start byte itself
    bus(1'h1, 8'h06, 8'h68, 4'hF, q);
    e = '{1'h1, 1'h1, 2'h0, gseq + off, 8'h21, 8'hC3 ^ 8'h20};
    send(1'h1, 2'h0, 8'h20, g);
    frm(e, g, 1'h1);
    chk("pend_zero", 32'h0, pend);
    chk("far_gaps", 32'h2, gaps);
    // Reset in mid-run drops an armed error and clears every field
    bus(1'h1, 8'h06, 8'h48, 4'hF, q);
    @(posedge i_clk);
    i_arst_n <= 1'h0;
    @(posedge i_clk);
    #1 chk("rst_pend", 32'h0, pend);
    @(posedge i_clk);
    i_arst_n <= 1'h1;
    off = 4'h0;
    bus(1'h0, 8'h06, 8'h00, 4'hF, q);
    chk("rst_ctrl", 32'h0, q);
    bus(1'h0, 8'h70, 8'h00, 4'hF, q);
    chk("rst_tgt", 32'h0, q);
    e = '{1'h1, 1'h1, 2'h1, gseq, 8'h01, 8'h3C};
    send(1'h1, 2'h1, 8'hFF, g);
    frm(e, g, 1'h1);
    close_out;
  end
endmodule // tb_ceir_top
